// File: hw/fbs_slave.v
// Fieldbus slave request checker and response generator
// Behaviour
// (RQ1) Exception reply sets function code top bit
// (RQ2) Exception reply adds one cause byte
// (RQ3) Cause 01: unknown function or drive fault
// (RQ4) Cause 02: bad address or address-length mix
// (RQ5) Cause 03: structurally illegal data field
// (RQ6) Cause 04: written value out of range
// (RQ7) Cause 05: password mismatch at check address
// (RQ8) Cause 06: wrong frame length or CRC
// (RQ9) Cause 07: write to read-only parameter
// (RQ10) Cause 08: write blocked while drive runs
// (RQ11) Cause 09: access while password lock active
// (RQ12) Good reply repeats request function code
// (RQ13) Good single write echoes whole request
// (RQ14) Read reply: count 2N, N words, CRC
// (RQ15) Run command register decodes values 1-8
// (RQ16) State word reads 0003 when stopped
// (RQ17) Values travel as scaled integers, stored raw
// (RQ18) Master retries or corrects after exception
// (RQ19) CRC-16 over frame, low byte first
// (RQ20) Addresses and data sent high byte first
`timescale 1ns/10ps
`default_nettype none
`include "fbs_map.vh"

module fbs_slave #(
   parameter        P_AW      = 6,
   parameter        P_DEPTH   = 64,
   parameter        P_MAXREAD = 16,
   parameter [15:0] P_RO_BASE = 16'h0030,
   parameter [15:0] P_RUNLOCK = 16'h0010,
   parameter [15:0] P_VAL_MAX = 16'hea60
) (
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   input  wire [7:0]  i_slave_addr,
   input  wire [15:0] i_password,
   input  wire        i_fault,
   input  wire        i_running,
   input  wire        i_reverse,
   input  wire        i_rx_valid,
   input  wire [7:0]  i_rx_byte,
   input  wire        i_rx_end,
   input  wire        i_tx_ready,
   output reg         o_tx_valid,
   output reg  [7:0]  o_tx_byte,
   output reg         o_tx_last,
   output reg  [15:0] o_run_cmd,
   output reg         o_cmd_strobe,
   output reg         o_busy
);

   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_CHECK = 3'h1;
   localparam [2:0] S_NEXT  = 3'h2;
   localparam [2:0] S_SEND  = 3'h3;
   localparam [2:0] S_FETCH = 3'h4;
   localparam [2:0] S_LDHI  = 3'h5;

   localparam [15:0] DEPTH16 = P_DEPTH[15:0];
   localparam [15:0] MAXRD16 = P_MAXREAD[15:0];

   reg  [2:0]  state_q;
   reg  [7:0]  cnt_q;
   reg  [7:0]  buf_q [0:5];
   reg  [7:0]  hdr_q [0:5];
   reg  [7:0]  idx_q;
   reg  [7:0]  len_q;
   reg         is_read_q;
   reg  [15:0] rd_addr_q;
   reg  [15:0] word_q;
   reg         lock_q;

   wire [15:0] rx_crc;
   wire [15:0] tx_crc;
   wire [15:0] mem_rdata;
   wire [7:0]  fn   = buf_q[1];
   wire [15:0] ra   = {buf_q[2], buf_q[3]};
   wire [15:0] rv   = {buf_q[4], buf_q[5]};
   wire [16:0] rend = {1'b0, ra} + {1'b0, rv};
   wire        tx_acc = (state_q == S_SEND) && i_tx_ready;

   reg         chk_ign;
   reg  [7:0]  chk_code;
   reg         chk_unlock;
   reg         chk_cmdwr;
   reg         chk_memwr;
   reg  [7:0]  nbyte;
   reg  [15:0] state_word;
   integer     k;

   // Drive state word for register reads
   always @* begin
      if (!i_running)
         state_word = `FBS_STATE_STOP; // RQ16
      else if (i_reverse)
         state_word = `FBS_STATE_REV;
      else
         state_word = `FBS_STATE_FWD;
   end

   // Request check, first failing cause wins
   always @* begin
      chk_ign    = (cnt_q < `FBS_MIN_LEN) || (buf_q[0] != i_slave_addr);
      chk_code   = 8'h00;
      chk_unlock = 1'b0;
      chk_cmdwr  = 1'b0;
      chk_memwr  = 1'b0;
      if (rx_crc != 16'h0000)
         chk_code = `FBS_EXC_FRAME; // RQ8
      else if (fn != `FBS_FN_READ && fn != `FBS_FN_WRITE)
         chk_code = `FBS_EXC_FUNC; // RQ3
      else if (cnt_q != `FBS_REQ_LEN)
         chk_code = `FBS_EXC_FRAME; // RQ8
      else if (lock_q && !(fn == `FBS_FN_WRITE && ra == `FBS_REG_PASSWORD))
         chk_code = `FBS_EXC_LOCKED; // RQ11
      else if (fn == `FBS_FN_READ) begin
         if (rv == 16'h0000 || rv > MAXRD16)
            chk_code = `FBS_EXC_DATA; // RQ5
         else if (!((rend <= {1'b0, DEPTH16}) ||
                    (rv == 16'h0001 && (ra == `FBS_REG_RUN_CMD ||
                                        ra == `FBS_REG_STATE))))
            chk_code = `FBS_EXC_ADDR; // RQ4
      end else if (ra == `FBS_REG_PASSWORD) begin
         if (rv != i_password)
            chk_code = `FBS_EXC_PASSWORD; // RQ7
         else
            chk_unlock = 1'b1;
      end else if (ra == `FBS_REG_STATE)
         chk_code = `FBS_EXC_READONLY; // RQ9
      else if (ra == `FBS_REG_RUN_CMD) begin
         if (rv < `FBS_CMD_FIRST || rv > `FBS_CMD_LAST)
            chk_code = `FBS_EXC_VALUE; // RQ15
         else
            chk_cmdwr = 1'b1;
      end else if (i_fault)
         chk_code = `FBS_EXC_FUNC; // RQ3
      else if (ra >= DEPTH16)
         chk_code = `FBS_EXC_ADDR; // RQ4
      else if (ra >= P_RO_BASE)
         chk_code = `FBS_EXC_READONLY; // RQ9
      else if (i_running && ra < P_RUNLOCK)
         chk_code = `FBS_EXC_RUNNING; // RQ10
      else if (rv > P_VAL_MAX)
         chk_code = `FBS_EXC_VALUE; // RQ6
      else
         chk_memwr = 1'b1;
   end

   // Byte at the current response position
   always @* begin
      if (idx_q == len_q)
         nbyte = tx_crc[7:0]; // RQ19
      else if (idx_q > len_q)
         nbyte = tx_crc[15:8];
      else if (is_read_q && idx_q >= 8'd3) begin
         if (!idx_q[0])
            nbyte = word_q[7:0];
         else
            nbyte = word_q[15:8]; // RQ20
      end else begin
         case (idx_q)
            8'd0:    nbyte = hdr_q[0];
            8'd1:    nbyte = hdr_q[1];
            8'd2:    nbyte = hdr_q[2];
            8'd3:    nbyte = hdr_q[3];
            8'd4:    nbyte = hdr_q[4];
            8'd5:    nbyte = hdr_q[5];
            default: nbyte = 8'h00;
         endcase
      end
   end

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q      <= S_IDLE;
         cnt_q        <= 8'h00;
         idx_q        <= 8'h00;
         len_q        <= 8'h00;
         is_read_q    <= 1'b0;
         rd_addr_q    <= 16'h0000;
         word_q       <= 16'h0000;
         lock_q       <= 1'b1;
         o_tx_valid   <= 1'b0;
         o_tx_byte    <= 8'h00;
         o_tx_last    <= 1'b0;
         o_run_cmd    <= 16'h0000;
         o_cmd_strobe <= 1'b0;
         o_busy       <= 1'b0;
         for (k = 0; k < 6; k = k + 1) begin
            buf_q[k] <= 8'h00;
            hdr_q[k] <= 8'h00;
         end
      end else begin
         o_cmd_strobe <= 1'b0;
         if (i_password == 16'h0000)
            lock_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               o_busy <= 1'b0;
               if (i_rx_valid) begin
                  if (cnt_q < 8'd6)
                     buf_q[cnt_q[2:0]] <= i_rx_byte;
                  if (cnt_q != 8'hff)
                     cnt_q <= cnt_q + 8'd1;
               end
               if (i_rx_end) begin
                  state_q <= S_CHECK;
                  o_busy  <= 1'b1;
               end
            end
            S_CHECK: begin
               cnt_q     <= 8'h00;
               idx_q     <= 8'h00;
               rd_addr_q <= ra;
               hdr_q[0]  <= buf_q[0];
               hdr_q[1]  <= fn; // RQ12
               is_read_q <= 1'b0;
               if (chk_ign)
                  state_q <= S_IDLE;
               else begin
                  state_q <= S_NEXT;
                  if (chk_code != 8'h00) begin
                     hdr_q[1] <= fn | `FBS_FN_EXC_BIT; // RQ1
                     hdr_q[2] <= chk_code; // RQ2
                     len_q    <= 8'd3;
                  end else if (fn == `FBS_FN_READ) begin
                     is_read_q <= 1'b1;
                     hdr_q[2]  <= {rv[6:0], 1'b0}; // RQ14
                     len_q     <= {rv[6:0], 1'b0} + 8'd3;
                  end else begin
                     for (k = 2; k < 6; k = k + 1)
                        hdr_q[k] <= buf_q[k]; // RQ13
                     len_q <= 8'd6;
                     if (chk_unlock)
                        lock_q <= 1'b0;
                     if (chk_cmdwr) begin
                        o_run_cmd    <= rv; // RQ15
                        o_cmd_strobe <= 1'b1;
                     end
                  end
               end
            end
            S_NEXT: begin
               o_tx_byte  <= nbyte;
               o_tx_valid <= 1'b1;
               o_tx_last  <= (idx_q > len_q);
               state_q    <= S_SEND;
            end
            S_SEND: begin
               if (i_tx_ready) begin
                  o_tx_valid <= 1'b0;
                  o_tx_last  <= 1'b0;
                  idx_q      <= idx_q + 8'd1;
                  if (idx_q > len_q)
                     state_q <= S_IDLE;
                  else if (is_read_q && idx_q >= 8'd2 && idx_q < len_q && idx_q[0] == 1'b0)
                     state_q <= S_FETCH;
                  else
                     state_q <= S_NEXT;
               end
            end
            S_FETCH: begin
               state_q <= S_LDHI;
            end
            S_LDHI: begin
               if (rd_addr_q == `FBS_REG_RUN_CMD)
                  word_q <= o_run_cmd;
               else if (rd_addr_q == `FBS_REG_STATE)
                  word_q <= state_word; // RQ16
               else
                  word_q <= mem_rdata;
               rd_addr_q <= rd_addr_q + 16'h0001;
               state_q   <= S_NEXT;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Receive check: CRC over the whole frame leaves zero residue
   fbs_crc16 u_rx_crc (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_clear   (state_q == S_CHECK),
      .i_en      (state_q == S_IDLE && i_rx_valid),
      .i_byte    (i_rx_byte),
      .o_crc     (rx_crc)
   ); // RQ19

   // Transmit CRC accumulates each accepted payload byte
   fbs_crc16 u_tx_crc (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_clear   (state_q == S_CHECK),
      .i_en      (tx_acc && idx_q < len_q),
      .i_byte    (o_tx_byte),
      .o_crc     (tx_crc)
   ); // RQ19

   // Parameters held as raw scaled integers
   fbs_param_mem #(
      .DW    (16),
      .AW    (P_AW),
      .DEPTH (P_DEPTH)
   ) u_mem (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_we      (state_q == S_CHECK && !chk_ign && chk_code == 8'h00 && chk_memwr),
      .i_waddr   (ra[P_AW-1:0]),
      .i_wdata   (rv),
      .i_re      (state_q == S_FETCH),
      .i_raddr   (rd_addr_q[P_AW-1:0]),
      .o_rdata   (mem_rdata)
   ); // RQ17

endmodule // fbs_slave
`default_nettype wire

// File: hw/fbs_map.vh
// Register offsets, function codes, cause codes and state word values
`ifndef FBS_MAP_VH
`define FBS_MAP_VH

`define FBS_FN_READ        8'h03
`define FBS_FN_WRITE       8'h06
`define FBS_FN_EXC_BIT     8'h80

`define FBS_EXC_FUNC       8'h01
`define FBS_EXC_ADDR       8'h02
`define FBS_EXC_DATA       8'h03
`define FBS_EXC_VALUE      8'h04
`define FBS_EXC_PASSWORD   8'h05
`define FBS_EXC_FRAME      8'h06
`define FBS_EXC_READONLY   8'h07
`define FBS_EXC_RUNNING    8'h08
`define FBS_EXC_LOCKED     8'h09

`define FBS_REG_RUN_CMD    16'h2000
`define FBS_REG_STATE      16'h2100
`define FBS_REG_PASSWORD   16'h2005

`define FBS_CMD_FIRST      16'h0001
`define FBS_CMD_LAST       16'h0008

`define FBS_STATE_FWD      16'h0001
`define FBS_STATE_REV      16'h0002
`define FBS_STATE_STOP     16'h0003

`define FBS_REQ_LEN        8'h08
`define FBS_MIN_LEN        8'h04
`define FBS_CRC_INIT       16'hffff
`define FBS_CRC_POLY       16'ha001

`endif

// File: hw/fbs_crc16.v
// Byte-serial CRC-16 accumulator for the serial bus frame check
`timescale 1ns/10ps
`default_nettype none
`include "fbs_map.vh"

module fbs_crc16 (
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   input  wire        i_clear,
   input  wire        i_en,
   input  wire [7:0]  i_byte,
   output reg  [15:0] o_crc
);

   function [15:0] crc_step;
      input [15:0] c;
      input [7:0]  b;
      integer      k;
      reg [15:0]   r;
      begin
         r = c ^ {8'h00, b};
         for (k = 0; k < 8; k = k + 1) begin
            if (r[0])
               r = (r >> 1) ^ `FBS_CRC_POLY;
            else
               r = r >> 1;
         end
         crc_step = r;
      end
   endfunction

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_crc <= `FBS_CRC_INIT;
      else if (i_clear)
         o_crc <= `FBS_CRC_INIT;
      else if (i_en)
         o_crc <= crc_step(o_crc, i_byte);
   end

endmodule // fbs_crc16
`default_nettype wire

// File: hw/fbs_param_mem.v
// Parameter store with registered read data
`timescale 1ns/10ps
`default_nettype none

module fbs_param_mem #(
   parameter DW    = 16,
   parameter AW    = 6,
   parameter DEPTH = 64
) (
   input  wire          i_ref_clk,
   input  wire          i_resetn,
   input  wire          i_we,
   input  wire [AW-1:0] i_waddr,
   input  wire [DW-1:0] i_wdata,
   input  wire          i_re,
   input  wire [AW-1:0] i_raddr,
   output reg  [DW-1:0] o_rdata
);

   reg [DW-1:0] mem [0:DEPTH-1];
   integer      k;

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (k = 0; k < DEPTH; k = k + 1)
            mem[k] <= {DW{1'b0}};
         o_rdata <= {DW{1'b0}};
      end else begin
         if (i_we)
            mem[i_waddr] <= i_wdata;
         if (i_re)
            o_rdata <= mem[i_raddr];
      end
   end

endmodule // fbs_param_mem
`default_nettype wire

// File: bench/fbs_slave_asserts.sv
// Port checker for the fieldbus slave
`timescale 1ns/10ps
`default_nettype none
module fbs_slave_asserts (
   input wire logic        i_ref_clk,
   input wire logic        i_resetn,
   input wire logic [7:0]  i_slave_addr,
   input wire logic        i_rx_end,
   input wire logic        i_tx_ready,
   input wire logic        o_tx_valid,
   input wire logic [7:0]  o_tx_byte,
   input wire logic        o_tx_last,
   input wire logic [15:0] o_run_cmd,
   input wire logic        o_cmd_strobe,
   input wire logic        o_busy
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence end_taken_s;
      i_rx_end && !o_busy;
   endsequence
   sequence check_s;
      o_busy ##1 o_busy;
   endsequence
   reply_start_a: assert property (end_taken_s ##1 check_s |=> o_tx_valid && o_tx_byte == i_slave_addr)
      else $error("reply start late or wrong");
   byte_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
      else $error("byte changed before accept");
   byte_gap_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
      else $error("no gap after accept");
   last_valid_a: assert property (o_tx_last |-> o_tx_valid)
      else $error("last flag without byte");
   reply_end_a: assert property (o_tx_valid && o_tx_last && i_tx_ready |-> ##[1:2] !o_busy)
      else $error("busy held after reply");
   idle_quiet_a: assert property (!o_busy |-> !o_tx_valid)
      else $error("byte sent while idle");
   strobe_once_a: assert property (o_cmd_strobe |=> !o_cmd_strobe)
      else $error("command strobe too long");
   cmd_range_a: assert property (o_cmd_strobe |-> o_run_cmd >= 16'h0001 && o_run_cmd <= 16'h0008)
      else $error("command out of range");
   cmd_change_a: assert property ($changed(o_run_cmd) |-> o_cmd_strobe && o_busy)
      else $error("command changed silently");
endmodule // fbs_slave_asserts
`default_nettype wire

// File: bench/fbs_master_model.sv
// Reply sink standing in for the bus master, prompt or stalling
`timescale 1ns/10ps
`default_nettype none
module fbs_master_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_slow,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic       i_tx_last,
   output var  logic       o_tx_ready
);
   logic [7:0] rx_q[$];
   int         n_frames = 0;
   int         cnt_q    = 0;
   initial o_tx_ready = 1'b0;
   always @(posedge i_ref_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         rx_q.push_back(i_tx_byte);
         if (i_tx_last)
            n_frames <= n_frames + 1;
      end
      cnt_q <= cnt_q + 1;
      o_tx_ready <= !i_slow || (cnt_q % 4 == 3);
   end
endmodule // fbs_master_model
`default_nettype wire

// File: bench/fbs_slave_tb.sv
// Testbench for the fieldbus slave
`timescale 1ns/10ps
`default_nettype none
module fbs_slave_tb;
   logic        i_ref_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [15:0] i_password = 16'h0000;
   logic        i_fault = 1'b0, i_running = 1'b0, i_reverse = 1'b0;
   logic        i_rx_valid = 1'b0, i_rx_end = 1'b0, slow = 1'b0;
   logic [7:0]  i_rx_byte = 8'h00;
   wire logic   o_tx_valid, o_tx_last, o_cmd_strobe, o_busy, i_tx_ready;
   wire logic [7:0]  o_tx_byte;
   wire logic [15:0] o_run_cmd;
   int          failures = 0, n_tests = 0, n0 = 0;
   logic [7:0]  fr[$], ex[$];

   always #4 i_ref_clk = ~i_ref_clk;

   fbs_slave uut (.i_ref_clk, .i_resetn, .i_slave_addr(8'h03), .i_password, .i_fault,
      .i_running, .i_reverse, .i_rx_valid, .i_rx_byte, .i_rx_end, .i_tx_ready,
      .o_tx_valid, .o_tx_byte, .o_tx_last, .o_run_cmd, .o_cmd_strobe, .o_busy);
   fbs_master_model mst (.i_ref_clk, .i_slow(slow), .i_tx_valid(o_tx_valid),
      .i_tx_byte(o_tx_byte), .i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready));

   function automatic void seal(ref logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp_w(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Bad 1 spoils the CRC, bad 2 drops a data byte
   task automatic send(input logic [7:0] fn, input logic [15:0] a, d, input int bad);
      mst.rx_q.delete();
      n0 = mst.n_frames;
      fr = '{8'h03, fn, a[15:8], a[7:0], d[15:8], d[7:0]};
      if (bad == 2)
         void'(fr.pop_back());
      seal(fr);
      if (bad == 1)
         fr[6] = ~fr[6];
      foreach (fr[i]) begin
         i_rx_valid <= 1'b1;
         i_rx_byte <= fr[i];
         @(posedge i_ref_clk);
      end
      i_rx_valid <= 1'b0;
      @(posedge i_ref_clk);
      i_rx_end <= 1'b1;
      @(posedge i_ref_clk);
      i_rx_end <= 1'b0;
   endtask

   task automatic chk();
      int k;
      logic bad;
      k = 0;
      while ((mst.n_frames == n0 || o_busy !== 1'b0) && k < 400) begin
         @(posedge i_ref_clk);
         k++;
      end
      bad = (mst.rx_q.size() != ex.size()) || (mst.n_frames != n0 + 1) || (k >= 400);
      foreach (ex[i])
         if (mst.rx_q[i] !== ex[i])
            bad = 1'b1;
      n_tests++;
      if (bad) begin
         failures++;
         $display("wrong value at %0t: reply bytes differ", $time);
      end
   endtask

   task automatic wr_ok(input logic [15:0] a, d);
      send(8'h06, a, d, 0);
      ex = fr;
      chk();
   endtask

   task automatic rd_ok(input logic [15:0] a, input int n, input logic [15:0] w0, w1);
      send(8'h03, a, n[15:0], 0);
      ex = '{8'h03, 8'h03, 8'(2 * n), w0[15:8], w0[7:0]};
      if (n == 2)
         ex = {ex, w1[15:8], w1[7:0]};
      seal(ex);
      chk();
   endtask

   task automatic err(input logic [7:0] fn, input logic [15:0] a, d, input int bad,
                      input logic [7:0] code);
      send(fn, a, d, bad);
      ex = '{8'h03, fn | 8'h80, code};
      seal(ex);
      chk();
   endtask

   // Watchdog: 34 frames of under 100 cycles each, with wide margin
   initial begin
      #200000;
      failures++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge i_ref_clk);
      cmp_w(o_run_cmd, 16'h0000);
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
      wr_ok(16'h2000, 16'h0001);
      cmp_w({fr[6], fr[7]}, 16'h4228);
      for (int v = 1; v <= 8; v++) begin
         slow <= v[0];
         wr_ok(16'h2000, v[15:0]);
         cmp_w(o_run_cmd, v[15:0]);
      end
      slow <= 1'b0;
      rd_ok(16'h2000, 1, 16'h0008, 16'h0000);
      rd_ok(16'h2100, 1, 16'h0003, 16'h0000);
      wr_ok(16'h0001, 16'h0032);
      rd_ok(16'h0001, 2, 16'h0032, 16'h0000);
      err(8'h05, 16'h0000, 16'h0001, 0, 8'h01);
      err(8'h06, 16'h2000, 16'h0002, 1, 8'h06);
      wr_ok(16'h2000, 16'h0002);
      err(8'h03, 16'h2100, 16'h0001, 2, 8'h06);
      err(8'h03, 16'h0000, 16'h0000, 0, 8'h03);
      err(8'h03, 16'h0040, 16'h0001, 0, 8'h02);
      err(8'h03, 16'h003f, 16'h0002, 0, 8'h02);
      err(8'h06, 16'h2100, 16'h0003, 0, 8'h07);
      err(8'h06, 16'h0030, 16'h0001, 0, 8'h07);
      err(8'h06, 16'h2000, 16'h0009, 0, 8'h04);
      err(8'h06, 16'h0002, 16'hea61, 0, 8'h04);
      wr_ok(16'h0002, 16'hea60);
      i_running <= 1'b1;
      i_reverse <= 1'b1;
      err(8'h06, 16'h0005, 16'h0001, 0, 8'h08);
      rd_ok(16'h2100, 1, 16'h0002, 16'h0000);
      wr_ok(16'h0010, 16'h0001);
      i_running <= 1'b0;
      i_fault <= 1'b1;
      err(8'h06, 16'h0002, 16'h0001, 0, 8'h01);
      wr_ok(16'h2000, 16'h0007);
      i_fault <= 1'b0;
      i_password <= 16'h1234;
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      cmp_w(o_run_cmd, 16'h0000);
      err(8'h03, 16'h2100, 16'h0001, 0, 8'h09);
      err(8'h06, 16'h2005, 16'h1111, 0, 8'h05);
      wr_ok(16'h2005, 16'h1234);
      rd_ok(16'h2100, 1, 16'h0003, 16'h0000);
      print_verdict();
   end
endmodule // fbs_slave_tb

bind fbs_slave fbs_slave_asserts chk_i (.i_ref_clk, .i_resetn, .i_slave_addr, .i_rx_end,
   .i_tx_ready, .o_tx_valid, .o_tx_byte, .o_tx_last, .o_run_cmd, .o_cmd_strobe, .o_busy);
`default_nettype wire
